/* adcc_core_model.sv */
// adcc_core_model.sv: core, sleep controller and analog input.
// assumes go_i pulses one cycle per sleep instruction.
`timescale 1ns/1ns
module adcc_core_model (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_n_i,
    // bench side
    input  wire       go_i,
    input  wire [2:0] mode_i,
    input  wire       other_irq_i,
    input  wire [9:0] vin_i,
    // converter side
    input  wire       wake_i,
    input  wire [9:0] dac_code_i,
    output reg        sleep_cmd_o,
    output reg  [2:0] sleep_mode_o,
    output reg        cpu_halted_o,
    output wire       cmp_o
);
    // vin is offset binary and never toggles mid conversion
    assign cmp_o = (vin_i >= dac_code_i);
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            sleep_cmd_o  <= 1'h0;
            sleep_mode_o <= 3'h0;
            cpu_halted_o <= 1'h0;
        end else begin
            sleep_cmd_o <= go_i;
            if (go_i) begin
                sleep_mode_o <= mode_i;
            end
            // halts after the sleep pulse; any wake source resumes it
            if (sleep_cmd_o) begin
                cpu_halted_o <= 1'h1;
            end else if (wake_i || other_irq_i) begin
                cpu_halted_o <= 1'h0;
            end
        end
    end
endmodule // adcc_core_model

/* adcc_map.vh */
// adcc_map.vh: register map, field positions, reset values and timing counts
// of the converter control block; assumes a 32-bit apb slave, word aligned.
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// register byte offsets
`define ADCC_OFF_CTRL      12'h000
`define ADCC_OFF_STATUS    12'h004
`define ADCC_OFF_MASK      12'h008
`define ADCC_OFF_RESULT    12'h00C
`define ADCC_OFF_SLEEP     12'h010

// control register fields
`define ADCC_CTRL_PWR      0
`define ADCC_CTRL_START    1
`define ADCC_CTRL_LADJ     2
`define ADCC_CTRL_DIFF     3

// status and mask fields (same layout)
`define ADCC_EV_DONE       0
`define ADCC_EV_SLPSTART   1
`define ADCC_EV_W          2

// sleep state fields
`define ADCC_SLP_ARMED     0
`define ADCC_SLP_CONV      1

// sleep mode codes from the sleep controller
`define ADCC_MODE_IDLE     3'h0
`define ADCC_MODE_NRED     3'h1

// conversion timing in converter clock ticks, then the msb trial code and the zero result code
`define ADCC_NORMAL_TICKS  5'h0D
`define ADCC_INIT_TICKS    5'h0C
`define ADCC_SAMPLE_END    5'h01
`define ADCC_FIRST_BIT     5'h02
`define ADCC_LAST_BIT      5'h0B
`define ADCC_MSB_TRIAL     10'h200
`define ADCC_RES_ZERO      10'h000

`endif

/* adcc_presc.v */
// adcc_presc.v: converter clock prescaler, one-cycle tick every DIV clocks.
// assumes the enable is the converter power bit; held in reset while low.
`timescale 1ns/1ns
module adcc_presc #(
    parameter DIV = 4,
    parameter CW  = 8
) (
    // clock and reset
    input  wire clk_i,
    input  wire rst_n_i,
    // control
    input  wire en_i,
    // tick
    output reg  tick_o
);
    reg [CW-1:0] cnt_reg;

    // counting restarts whenever power goes off, so phase is fixed at power-on
    always @(posedge clk_i) begin
        if (!rst_n_i || !en_i) begin
            cnt_reg <= {CW{1'b0}};
            tick_o  <= 1'b0;
        end else if (cnt_reg == DIV[CW-1:0] - 1'b1) begin
            cnt_reg <= {CW{1'b0}};
            tick_o  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick_o  <= 1'b0;
        end
    end
endmodule // adcc_presc

/* adcc_top.v */
// adcc_top.v: 10-bit successive-approximation converter control with apb
// registers, sleep-started conversion and result justification.
// assumes an external analog comparator and dac; all inputs synchronous.
//
// Operation
// - entering idle or noise-reduction sleep with the converter prepared starts a conversion once the core halts.
// - a sleep-started conversion that completes while the core is halted wakes the core via the completion interrupt.
// - if another source woke the core first, the completion interrupt is still raised when the conversion ends.
// - after waking, no further sleep-triggered conversion happens until a new sleep command.
// - other sleep modes never switch the converter off by themselves.
// - once the done flag reads high the result registers hold the finished result.
// - single-ended results are unsigned 10-bit codes from 0x000 to 0x3FF.
// - differential results are 10-bit two's complement codes from 0x200 to 0x1FF, saturating at 0x1FF.
// - at completion the result is stored, the done flag set and the start bit cleared in the same cycle.
// - changing the justify select changes the presented result at once, even during a conversion.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "adcc_map.vh"
module adcc_top #(
    parameter PRESC_DIV = 4,
    parameter AW        = 12
) (
    // clock and reset
    input  wire          clk_i,
    input  wire          rst_n_i,
    // apb slave
    input  wire          psel_i,
    input  wire          penable_i,
    input  wire          pwrite_i,
    input  wire [AW-1:0] paddr_i,
    input  wire [31:0]   pwdata_i,
    output reg  [31:0]   prdata_o,
    output reg           pready_o,
    output reg           pslverr_o,
    // sleep controller
    input  wire          sleep_cmd_i,
    input  wire [2:0]    sleep_mode_i,
    input  wire          cpu_halted_i,
    output reg           wake_o,
    output reg           irq_o,
    // analog front end
    input  wire          cmp_i,
    output reg  [9:0]    dac_code_o,
    output reg           sample_o,
    output reg           analog_on_o
);
    // control state
    reg        converter_power_on_reg;
    reg        conversion_start_bit_reg;
    reg        left_justify_select_reg;
    reg        diff_sel_reg;
    reg [`ADCC_EV_W-1:0] status_reg;
    reg [`ADCC_EV_W-1:0] status_next;
    reg [`ADCC_EV_W-1:0] mask_reg;
    reg [9:0]  result_reg;
    reg        run_reg;
    reg        first_reg;
    reg        init_reg;
    reg [4:0]  cnt_reg;
    reg [9:0]  dac_next;
    reg        armed_reg;
    reg        slp_conv_reg;

    // apb decode
    wire       acc_start = psel_i & penable_i & ~pready_o;
    wire       wr_fire   = psel_i & penable_i & pready_o & pwrite_i;
    wire       sel_ctrl  = (paddr_i == `ADCC_OFF_CTRL);
    wire       sel_stat  = (paddr_i == `ADCC_OFF_STATUS);
    wire       sel_mask  = (paddr_i == `ADCC_OFF_MASK);
    wire       sel_res   = (paddr_i == `ADCC_OFF_RESULT);
    wire       sel_slp   = (paddr_i == `ADCC_OFF_SLEEP);
    wire       mapped    = sel_ctrl | sel_stat | sel_mask | sel_res | sel_slp;

    // converter clock enable
    wire       tick;
    adcc_presc #(
        .DIV (PRESC_DIV),
        .CW  (8)
    ) u_presc (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (converter_power_on_reg),
        .tick_o  (tick)
    );

    wire       busy      = conversion_start_bit_reg | run_reg;
    wire       bit_step  = run_reg & ~init_reg & tick &
                           (cnt_reg >= `ADCC_FIRST_BIT) & (cnt_reg <= `ADCC_LAST_BIT);
    // five-bit difference cut on purpose; the bit index never exceeds 9
    wire [4:0] bidx_full = `ADCC_LAST_BIT - cnt_reg;
    wire [3:0] bidx      = bidx_full[3:0];
    wire       complete  = run_reg & ~init_reg & tick &
                           (cnt_reg == `ADCC_NORMAL_TICKS - 1'b1);
    // offset-binary search result; msb flip gives two's complement, so full
    // positive input saturates at 0x1FF with no extra logic
    wire [9:0] code_se   = dac_next;
    wire [9:0] code_df   = {~dac_next[9], dac_next[8:0]};
    wire       mode_ok   = (sleep_mode_i == `ADCC_MODE_IDLE) |
                           (sleep_mode_i == `ADCC_MODE_NRED);
    // only a prepared converter is started; the core keeps the rest
    wire       prepared  = converter_power_on_reg & ~busy & mask_reg[`ADCC_EV_DONE];
    wire       slp_go    = armed_reg & cpu_halted_i & prepared;

    // presented result, re-muxed every read so the select acts at once
    wire [7:0] res_hi    = left_justify_select_reg ? result_reg[9:2]
                                                   : {6'h00, result_reg[9:8]};
    wire [7:0] res_lo    = left_justify_select_reg ? {result_reg[1:0], 6'h00}
                                                   : result_reg[7:0];

    // successive approximation step
    always @* begin
        dac_next = dac_code_o;
        if (bit_step) begin
            if (!cmp_i) begin
                dac_next[bidx] = 1'b0;
            end
            if (bidx != 4'h0) begin
                dac_next[bidx - 4'h1] = 1'b1;
            end
        end
    end

    // event flags: hardware set wins over a write-one clear
    always @* begin
        status_next = status_reg;
        if (wr_fire && sel_stat) begin
            status_next = status_next & ~pwdata_i[`ADCC_EV_W-1:0];
        end
        if (complete) begin
            status_next[`ADCC_EV_DONE] = 1'b1;
        end
        if (slp_go) begin
            status_next[`ADCC_EV_SLPSTART] = 1'b1;
        end
    end

    // apb answer, one wait state
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= acc_start;
            pslverr_o <= acc_start & ~mapped;
            if (acc_start && !pwrite_i) begin
                if (sel_ctrl) begin
                    prdata_o <= {28'h000_0000, diff_sel_reg, left_justify_select_reg,
                                 busy, converter_power_on_reg};
                end else if (sel_stat) begin
                    prdata_o <= {30'h0000_0000, status_reg};
                end else if (sel_mask) begin
                    prdata_o <= {30'h0000_0000, mask_reg};
                end else if (sel_res) begin
                    prdata_o <= {16'h0000, res_hi, res_lo};
                end else if (sel_slp) begin
                    prdata_o <= {30'h0000_0000, slp_conv_reg, armed_reg};
                end else begin
                    prdata_o <= 32'h0000_0000;
                end
            end
        end
    end

    // software controls
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            converter_power_on_reg  <= 1'b0;
            left_justify_select_reg <= 1'b0;
            diff_sel_reg            <= 1'b0;
            mask_reg                <= {`ADCC_EV_W{1'b0}};
            status_reg              <= {`ADCC_EV_W{1'b0}};
        end else begin
            status_reg <= status_next;
            if (wr_fire && sel_ctrl) begin
                // sleep entry never touches power; only software clears it
                converter_power_on_reg  <= pwdata_i[`ADCC_CTRL_PWR];
                left_justify_select_reg <= pwdata_i[`ADCC_CTRL_LADJ];
                diff_sel_reg            <= pwdata_i[`ADCC_CTRL_DIFF];
            end
            if (wr_fire && sel_mask) begin
                mask_reg <= pwdata_i[`ADCC_EV_W-1:0];
            end
        end
    end

    // conversion sequencer
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            conversion_start_bit_reg <= 1'b0;
            run_reg                  <= 1'b0;
            first_reg                <= 1'b1;
            init_reg                 <= 1'b0;
            cnt_reg                  <= 5'h00;
            dac_code_o               <= `ADCC_RES_ZERO;
            sample_o                 <= 1'b0;
            result_reg               <= `ADCC_RES_ZERO;
        end else if (!converter_power_on_reg) begin
            // power off aborts any conversion; next start is a first one
            conversion_start_bit_reg <= wr_fire & sel_ctrl & pwdata_i[`ADCC_CTRL_START] &
                                        pwdata_i[`ADCC_CTRL_PWR];
            run_reg                  <= 1'b0;
            first_reg                <= 1'b1;
            init_reg                 <= 1'b0;
            cnt_reg                  <= 5'h00;
            sample_o                 <= 1'b0;
        end else begin
            dac_code_o <= dac_next;
            if ((wr_fire && sel_ctrl && pwdata_i[`ADCC_CTRL_START]) || slp_go) begin
                conversion_start_bit_reg <= 1'b1;
            end
            if (conversion_start_bit_reg && !run_reg && tick) begin
                run_reg    <= 1'b1;
                init_reg   <= first_reg;
                first_reg  <= 1'b0;
                cnt_reg    <= 5'h00;
                sample_o   <= ~first_reg;
                dac_code_o <= `ADCC_RES_ZERO;
            end else if (run_reg && tick) begin
                if (init_reg && cnt_reg == `ADCC_INIT_TICKS - 1'b1) begin
                    init_reg <= 1'b0;
                    cnt_reg  <= 5'h00;
                    sample_o <= 1'b1;
                end else if (complete) begin
                    // result, done flag and start bit all change on this edge
                    run_reg                  <= 1'b0;
                    conversion_start_bit_reg <= 1'b0;
                    result_reg               <= diff_sel_reg ? code_df : code_se;
                    cnt_reg                  <= 5'h00;
                end else begin
                    cnt_reg <= cnt_reg + 5'h01;
                    if (!init_reg && cnt_reg == `ADCC_SAMPLE_END) begin
                        sample_o   <= 1'b0;
                        dac_code_o <= `ADCC_MSB_TRIAL;
                    end
                end
            end
        end
    end

    // sleep handshake
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            armed_reg    <= 1'b0;
            slp_conv_reg <= 1'b0;
            wake_o       <= 1'b0;
            irq_o        <= 1'b0;
            analog_on_o  <= 1'b0;
        end else begin
            analog_on_o <= converter_power_on_reg;
            irq_o       <= |(status_next & mask_reg);
            if (sleep_cmd_i) begin
                armed_reg <= mode_ok;
            end else if (slp_go || !converter_power_on_reg) begin
                // one conversion per sleep command; stays idle after wake
                armed_reg <= 1'b0;
            end
            if (slp_go) begin
                slp_conv_reg <= 1'b1;
            end else if (complete || !converter_power_on_reg) begin
                slp_conv_reg <= 1'b0;
            end
            if (complete && slp_conv_reg && cpu_halted_i) begin
                wake_o <= 1'b1;
            end else if (!cpu_halted_i) begin
                wake_o <= 1'b0;
            end
        end
    end
endmodule // adcc_top

/* adcc_top_assertions.sv */
// adcc_top_assertions.sv: port checks for the converter control block.
// assumes the apb master holds requests until ready.
`timescale 1ns/1ns
`include "adcc_map.vh"
module adcc_chk #(
    parameter AW = 12
) (
    // clock, reset, apb
    input wire          clk_i,
    input wire          rst_n_i,
    input wire          psel_i,
    input wire          penable_i,
    input wire          pwrite_i,
    input wire [AW-1:0] paddr_i,
    input wire [31:0]   pwdata_i,
    input wire [31:0]   prdata_o,
    input wire          pready_o,
    input wire          pslverr_o,
    // sleep and power
    input wire          cpu_halted_i,
    input wire          wake_o,
    input wire          irq_o,
    input wire          analog_on_o
);
    // power bit may only fall through a control write
    wire pwr_off_wr = psel_i & penable_i & pwrite_i & pready_o & ~pwdata_i[`ADCC_CTRL_PWR]
        & (paddr_i == `ADCC_OFF_CTRL);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wait; psel_i && penable_i && !pready_o; endsequence
    sequence s_run; !cpu_halted_i [*2]; endsequence
    a_ready_one_wait: assert property (s_wait |=> pready_o)
        else $error("ready late");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    a_slverr_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_unmapped_err: assert property (pready_o |-> (pslverr_o == (paddr_i > `ADCC_OFF_SLEEP))
        && (!pslverr_o || pwrite_i || prdata_o == 32'h0000_0000)) else $error("bad error");
    a_wake_holds: assert property (wake_o && cpu_halted_i |=> wake_o)
        else $error("wake dropped");
    a_wake_drop: assert property (s_run |-> !wake_o)
        else $error("wake while running");
    a_wake_halted: assert property ($rose(wake_o) |-> $past(cpu_halted_i))
        else $error("wake not halted");
    a_wake_irq: assert property ($rose(wake_o) |=> irq_o)
        else $error("wake without irq");
    a_power_kept: assert property ($fell(analog_on_o) |-> $past(pwr_off_wr)
        || $past(pwr_off_wr, 2)) else $error("power lost");
endmodule // adcc_chk
bind adcc_top adcc_chk #(.AW(AW)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .cpu_halted_i(cpu_halted_i), .wake_o(wake_o), .irq_o(irq_o), .analog_on_o(analog_on_o));

/* tb_adc_sleep_convert_result_format.sv */
// tb_adc_sleep_convert_result_format.sv: self-checking bench of adcc_top.
// assumes the core model on the far side and a short prescaler.
`timescale 1ns/1ns
`include "adcc_map.vh"
module tb_adc_sleep_convert_result_format;
    logic        clk_i = 1'h0;
    logic        rst_n_i = 1'h0;
    logic        psel_i = 1'h0;
    logic        penable_i = 1'h0;
    logic        pwrite_i = 1'h0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic        go = 1'h0;
    logic        other = 1'h0;
    logic [2:0]  mode = 3'h0;
    logic [9:0]  vin = 10'h000;
    logic [31:0] rdata;
    logic        rerr;
    wire  [31:0] prdata_o;
    wire  [9:0]  dac;
    wire  [2:0]  smode;
    wire         pready_o, pslverr_o, wake_o, irq_o, analog_on_o, scmd, halted, cmp;
    wire         samp;
    integer      failures = 0;
    integer      cmp_count = 0;
    integer      i, n;
    // rows: differential, left justify, code, expected result
    logic [27:0] rows [0:5] = '{{1'h0, 1'h0, 10'h000, 16'h0000}, {1'h0, 1'h1, 10'h3FF, 16'hFFC0},
        {1'h0, 1'h0, 10'h3FF, 16'h03FF}, {1'h1, 1'h1, 10'h3A3, 16'hE8C0},
        {1'h1, 1'h0, 10'h200, 16'h0200}, {1'h1, 1'h0, 10'h1FF, 16'h01FF}};
    always #5 clk_i = ~clk_i;
    adcc_top #(.PRESC_DIV(2)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sleep_cmd_i(scmd),
        .sleep_mode_i(smode), .cpu_halted_i(halted), .wake_o(wake_o), .irq_o(irq_o),
        .cmp_i(cmp), .dac_code_o(dac), .sample_o(samp), .analog_on_o(analog_on_o));
    adcc_core_model u_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .mode_i(mode),
        .other_irq_i(other), .vin_i(vin), .wake_i(wake_o), .dac_code_i(dac),
        .sleep_cmd_o(scmd), .sleep_mode_o(smode), .cpu_halted_o(halted), .cmp_o(cmp));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task give_up(input logic hit);
        if (hit) begin
            chk("wait", 32'h0000_0000, 32'h0000_0001);
            test_done;
        end
    endtask
    // request held until ready is sampled high, then one idle cycle
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer k;
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        k = 0;
        do begin
            @(posedge clk_i);
            k = k + 1;
        end while (pready_o !== 1'h1 && k < 50);
        give_up(k >= 50);
        rdata = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        @(posedge clk_i);
    endtask
    task run_conv(input logic [3:0] c);
        apb(1'h1, `ADCC_OFF_CTRL, {28'h000_0000, c});
        rdata = 32'h0000_0002;
        for (n = 0; n < 100 && rdata[1] === 1'h1; n = n + 1) begin
            apb(1'h0, `ADCC_OFF_CTRL, 32'h0000_0000);
        end
        give_up(rdata[1] !== 1'h0);
    endtask
    task wait_on(input logic wk);
        for (n = 0; n < 1000 && (wk ? wake_o : irq_o) !== 1'h1; n = n + 1) begin
            @(posedge clk_i);
        end
        give_up(n >= 1000);
    endtask
    task sleep_go(input logic [2:0] m);
        go <= 1'h1;
        mode <= m;
        @(posedge clk_i);
        go <= 1'h0;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(posedge clk_i);
        for (i = 0; i < 6; i = i + 1) begin
            // comparator sees offset binary for differential codes
            vin <= rows[i][27] ? rows[i][25:16] ^ 10'h200 : rows[i][25:16];
            run_conv({rows[i][27:26], 2'h3});
            apb(1'h0, `ADCC_OFF_STATUS, 32'h0000_0000);
            chk("done", rdata, 32'h0000_0001);
            apb(1'h0, `ADCC_OFF_RESULT, 32'h0000_0000);
            chk("result", rdata, {16'h0000, rows[i][15:0]});
            chk("masked irq", irq_o, 32'h0000_0000);
            apb(1'h1, `ADCC_OFF_STATUS, 32'h0000_0001);
        end
        apb(1'h1, `ADCC_OFF_CTRL, 32'h0000_000D);
        apb(1'h0, `ADCC_OFF_RESULT, 32'h0000_0000);
        chk("relabel", rdata, 32'h0000_7FC0);
        run_conv(4'h3);
        apb(1'h1, `ADCC_OFF_MASK, 32'h0000_0001);
        @(posedge clk_i);
        chk("irq on", irq_o, 32'h0000_0001);
        apb(1'h1, `ADCC_OFF_STATUS, 32'h0000_0001);
        @(posedge clk_i);
        chk("irq off", irq_o, 32'h0000_0000);
        rst_n_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(posedge clk_i);
        chk("sample idle", samp, 32'h0000_0000);
        chk("analog off", analog_on_o, 32'h0000_0000);
        for (i = 0; i < 6; i = i + 1) begin
            apb(1'h0, {i[9:0], 2'h0} + 12'h000, 32'h0000_0000);
            chk("reset value", rdata, 32'h0000_0000);
            chk("slave error", rerr, i / 5);
        end
        apb(1'h1, `ADCC_OFF_MASK, 32'h0000_0001);
        apb(1'h1, `ADCC_OFF_CTRL, 32'h0000_0001);
        sleep_go(`ADCC_MODE_NRED);
        wait_on(1'h1);
        @(posedge clk_i);
        chk("wake irq", irq_o, 32'h0000_0001);
        apb(1'h0, `ADCC_OFF_STATUS, 32'h0000_0000);
        chk("sleep start", rdata, 32'h0000_0003);
        apb(1'h0, `ADCC_OFF_SLEEP, 32'h0000_0000);
        chk("disarmed", rdata, 32'h0000_0000);
        apb(1'h1, `ADCC_OFF_STATUS, 32'h0000_0003);
        sleep_go(`ADCC_MODE_IDLE);
        repeat (5) @(posedge clk_i);
        other <= 1'h1;
        @(posedge clk_i);
        other <= 1'h0;
        wait_on(1'h0);
        chk("early wake", wake_o, 32'h0000_0000);
        apb(1'h0, `ADCC_OFF_STATUS, 32'h0000_0000);
        chk("late done", rdata, 32'h0000_0003);
        apb(1'h1, `ADCC_OFF_STATUS, 32'h0000_0003);
        sleep_go(3'h3);
        repeat (100) @(posedge clk_i);
        chk("power kept", analog_on_o, 32'h0000_0001);
        apb(1'h0, `ADCC_OFF_STATUS, 32'h0000_0000);
        chk("no start", rdata, 32'h0000_0000);
        other <= 1'h1;
        @(posedge clk_i);
        other <= 1'h0;
        apb(1'h1, `ADCC_OFF_CTRL, 32'h0000_0000);
        @(posedge clk_i);
        chk("power off", analog_on_o, 32'h0000_0000);
        test_done;
    end
endmodule // tb_adc_sleep_convert_result_format
